// file: rtl/lde_pkg.sv
// Constants and types shared by the line-draw engine files.
package lde_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MEM_AW = 32;
  localparam int ACC_W = 12;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PATTERN = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LINE_INIT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LINE_INC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STRIDE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DEST_PIX = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_SRC_PIX = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_DEST_START = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_WIDTH = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_HEIGHT = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_FOREGROUND = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_BACKGROUND = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h30;

  // Control register bits.
  localparam int CTL_ENABLE = 0;
  localparam int CTL_LINE = 1;
  localparam int CTL_XDIR = 2;
  localparam int CTL_YDIR = 3;
  localparam int CTL_BGSEL = 4;
  localparam int CTL_DEPTH_LO = 5;
  localparam int CTL_DEPTH_HI = 7;
  localparam int CTL_IRQEN = 8;
  localparam int CTL_W = 9;

  // Field positions inside other registers.
  localparam int PAT_LAST_LO = 16;
  localparam int PAT_LAST_HI = 19;
  localparam int ACC_X_LO = 0;
  localparam int ACC_Y_LO = 16;
  localparam int POS_FIRST_LO = 0;
  localparam int POS_LAST_LO = 8;
  localparam int POS_W = 5;

  // Pixel depth codes and their widths in bits.
  localparam logic [2:0] DEPTH_4 = 3'h2;
  localparam logic [2:0] DEPTH_8 = 3'h3;
  localparam logic [2:0] DEPTH_16 = 3'h4;
  localparam logic [2:0] DEPTH_32 = 3'h6;
  localparam logic [5:0] BITS_4 = 6'h04;
  localparam logic [5:0] BITS_8 = 6'h08;
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] BITS_32 = 6'h20;

  localparam logic [3:0] PAT_IDX_FIRST = 4'h0;
  localparam logic [ACC_W-1:0] ACC_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b011,
    ST_STEP = 3'b010,
    ST_DONE = 3'b110
  } lde_state_type;
endpackage

// file: rtl/lde_pixel_merge.sv
// Inserts one pixel of colour into a 32-bit frame-buffer word.
`timescale 1ns/100ps
`default_nettype none
module lde_pixel_merge (
  input wire logic [lde_pkg::DATA_W-1:0] old_word,
  input wire logic [lde_pkg::DATA_W-1:0] color,
  input wire logic [lde_pkg::POS_W-1:0] bitpos,
  input wire logic [5:0] pix_bits,
  output logic [lde_pkg::DATA_W-1:0] new_word
);
  import lde_pkg::*;

  logic [2*DATA_W-1:0] ones;
  logic [2*DATA_W-1:0] mask;
  logic [2*DATA_W-1:0] shifted;

  always_comb begin
    ones = (64'h1 << pix_bits) - 64'h1;
    mask = ones << bitpos;
    shifted = ({32'h0000_0000, color} & ones) << bitpos;
  end

  // Only the bits of the pixel are replaced; neighbours in the word stay.
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    assign new_word[i] = mask[i] ? shifted[i] : old_word[i];
  end
endmodule
`default_nettype wire

// file: rtl/lde_engine.sv
// Line-draw engine: register file, incremental line walker and frame-buffer access.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module lde_engine (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [lde_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lde_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [lde_pkg::DATA_W-1:0] reg_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [lde_pkg::MEM_AW-1:0] mem_addr,
  output logic [lde_pkg::DATA_W-1:0] mem_wdata,
  input wire logic [lde_pkg::DATA_W-1:0] mem_rdata,
  input wire logic mem_ack,
  output logic done_irq
);
  import lde_pkg::*;

  logic [CTL_W-1:0] engine_control_q;
  logic [15:0] onoff_pattern_q;
  logic [3:0] pattern_last_bit_q;
  logic [ACC_W-1:0] x_accum_init_q;
  logic [ACC_W-1:0] y_accum_init_q;
  logic [ACC_W-1:0] x_step_increment_q;
  logic [ACC_W-1:0] y_step_increment_q;
  logic [MEM_AW-1:0] dest_stride_q;
  logic [POS_W-1:0] dest_first_q;
  logic [POS_W-1:0] dest_last_q;
  logic [POS_W-1:0] src_first_q;
  logic [POS_W-1:0] src_last_q;
  logic [MEM_AW-1:0] dest_start_addr_q;
  logic [ACC_W-1:0] dest_width_q;
  logic [ACC_W-1:0] dest_height_q;
  logic [DATA_W-1:0] foreground_q;
  logic [DATA_W-1:0] background_q;
  lde_state_type state_q;
  logic [ACC_W-1:0] x_acc_q;
  logic [ACC_W-1:0] y_acc_q;
  logic [MEM_AW-1:0] word_addr_q;
  logic [POS_W-1:0] bitpos_q;
  logic [3:0] pat_idx_q;
  logic [ACC_W:0] x_moves_q;
  logic [DATA_W-1:0] old_word_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [MEM_AW-1:0] mem_addr_q;
  logic [DATA_W-1:0] mem_wdata_q;
  logic [DATA_W-1:0] reg_rdata_q;
  logic done_irq_q;
  logic wr_control;
  logic start;
  logic finish;
  logic bg_sel;
  logic x_dir;
  logic y_dir;
  logic paint;
  logic pix_on;
  logic [5:0] pix_bits;
  logic [DATA_W-1:0] pix_color;
  logic [DATA_W-1:0] merged_word;
  logic [ACC_W:0] x_sum;
  logic [ACC_W:0] y_sum;
  logic [5:0] bit_next;
  logic [POS_W-1:0] bitpos_d;
  logic [MEM_AW-1:0] word_addr_d;
  logic [3:0] pat_idx_d;
  logic at_end;
  assign wr_control = reg_write && (reg_addr == OFF_CONTROL);
  assign bg_sel = engine_control_q[CTL_BGSEL];
  assign x_dir = engine_control_q[CTL_XDIR];
  assign y_dir = engine_control_q[CTL_YDIR];
  // A draw begins when software sets enable with line mode selected and the engine is idle.
  assign start = (state_q == ST_IDLE) && engine_control_q[CTL_ENABLE] && engine_control_q[CTL_LINE];
  assign finish = (state_q == ST_DONE);

  always_comb begin
    case (engine_control_q[CTL_DEPTH_HI:CTL_DEPTH_LO])
      DEPTH_4: pix_bits = BITS_4;
      DEPTH_8: pix_bits = BITS_8;
      DEPTH_32: pix_bits = BITS_32;
      default: pix_bits = BITS_16;
    endcase
  end

  assign pix_on = onoff_pattern_q[pat_idx_q];
  // The index register still holds the last line's value at start, so bit 0 is read directly.
  assign paint = onoff_pattern_q[PAT_IDX_FIRST] || bg_sel;
  assign pix_color = pix_on ? foreground_q : background_q;

  lde_pixel_merge u_merge (
    .old_word(old_word_q),
    .color(pix_color),
    .bitpos(bitpos_q),
    .pix_bits(pix_bits),
    .new_word(merged_word)
  );

  always_comb begin
    x_sum = {1'b0, x_acc_q} + {1'b0, x_step_increment_q};
    y_sum = {1'b0, y_acc_q} + {1'b0, y_step_increment_q};
    word_addr_d = word_addr_q;
    bitpos_d = bitpos_q;
    bit_next = 6'h00;
    if (x_sum[ACC_W]) begin
      if (x_dir) begin
        bit_next = {1'b0, bitpos_q} + pix_bits;
        if (bit_next >= BITS_32) begin
          bit_next = bit_next - BITS_32;
          word_addr_d = word_addr_d + 32'h0000_0001;
        end
      end else begin
        if ({1'b0, bitpos_q} < pix_bits) begin
          bit_next = {1'b0, bitpos_q} + BITS_32 - pix_bits;
          word_addr_d = word_addr_d - 32'h0000_0001;
        end else begin
          bit_next = {1'b0, bitpos_q} - pix_bits;
        end
      end
      bitpos_d = bit_next[POS_W-1:0];
    end
    if (y_sum[ACC_W]) begin
      if (y_dir) begin
        word_addr_d = word_addr_d + dest_stride_q;
      end else begin
        word_addr_d = word_addr_d - dest_stride_q;
      end
    end
    pat_idx_d = (pat_idx_q == pattern_last_bit_q) ? PAT_IDX_FIRST : pat_idx_q + 4'h1;
  end

  // The last pixel is the one reached after width plus one horizontal moves.
  assign at_end = (x_moves_q == ({1'b0, dest_width_q} + 13'h0001));

  // Register writes; the engine's own clear of enable yields to a software write.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      engine_control_q <= '0;
    end else if (wr_control) begin
      engine_control_q <= reg_wdata[CTL_W-1:0];
    end else if (finish) begin
      engine_control_q[CTL_ENABLE] <= 1'b0;
    end else if (state_q == ST_IDLE && engine_control_q[CTL_ENABLE] && !engine_control_q[CTL_LINE]) begin
      engine_control_q[CTL_ENABLE] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      onoff_pattern_q <= 16'h0000;
      pattern_last_bit_q <= 4'h0;
      x_accum_init_q <= ACC_ZERO;
      y_accum_init_q <= ACC_ZERO;
      x_step_increment_q <= ACC_ZERO;
      y_step_increment_q <= ACC_ZERO;
      dest_stride_q <= WORD_ZERO;
      dest_first_q <= '0;
      dest_last_q <= '0;
      src_first_q <= '0;
      src_last_q <= '0;
      dest_start_addr_q <= WORD_ZERO;
      dest_width_q <= ACC_ZERO;
      dest_height_q <= ACC_ZERO;
      foreground_q <= WORD_ZERO;
      background_q <= WORD_ZERO;
    end else if (reg_write) begin
      case (reg_addr)
        OFF_PATTERN: begin
          onoff_pattern_q <= reg_wdata[15:0];
          pattern_last_bit_q <= reg_wdata[PAT_LAST_HI:PAT_LAST_LO];
        end
        OFF_LINE_INIT: begin
          x_accum_init_q <= reg_wdata[ACC_X_LO +: ACC_W];
          y_accum_init_q <= reg_wdata[ACC_Y_LO +: ACC_W];
        end
        OFF_LINE_INC: begin
          x_step_increment_q <= reg_wdata[ACC_X_LO +: ACC_W];
          y_step_increment_q <= reg_wdata[ACC_Y_LO +: ACC_W];
        end
        OFF_STRIDE: dest_stride_q <= reg_wdata;
        OFF_DEST_PIX: begin
          dest_first_q <= reg_wdata[POS_FIRST_LO +: POS_W];
          dest_last_q <= reg_wdata[POS_LAST_LO +: POS_W];
        end
        OFF_SRC_PIX: begin
          src_first_q <= reg_wdata[POS_FIRST_LO +: POS_W];
          src_last_q <= reg_wdata[POS_LAST_LO +: POS_W];
        end
        OFF_DEST_START: dest_start_addr_q <= reg_wdata;
        OFF_WIDTH: dest_width_q <= reg_wdata[ACC_W-1:0];
        OFF_HEIGHT: dest_height_q <= reg_wdata[ACC_W-1:0];
        OFF_FOREGROUND: foreground_q <= reg_wdata;
        OFF_BACKGROUND: background_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data stands in the cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= WORD_ZERO;
    end else if (reg_read) begin
      case (reg_addr)
        OFF_CONTROL: reg_rdata_q <= {23'h000000, engine_control_q};
        OFF_PATTERN: reg_rdata_q <= {12'h000, pattern_last_bit_q, onoff_pattern_q};
        OFF_LINE_INIT: reg_rdata_q <= {4'h0, y_accum_init_q, 4'h0, x_accum_init_q};
        OFF_LINE_INC: reg_rdata_q <= {4'h0, y_step_increment_q, 4'h0, x_step_increment_q};
        OFF_STRIDE: reg_rdata_q <= dest_stride_q;
        OFF_DEST_PIX: reg_rdata_q <= {19'h00000, dest_last_q, 3'h0, dest_first_q};
        OFF_SRC_PIX: reg_rdata_q <= {19'h00000, src_last_q, 3'h0, src_first_q};
        OFF_DEST_START: reg_rdata_q <= dest_start_addr_q;
        OFF_WIDTH: reg_rdata_q <= {20'h00000, dest_width_q};
        OFF_HEIGHT: reg_rdata_q <= {20'h00000, dest_height_q};
        OFF_FOREGROUND: reg_rdata_q <= foreground_q;
        OFF_BACKGROUND: reg_rdata_q <= background_q;
        OFF_STATUS: reg_rdata_q <= word_addr_q;
        default: reg_rdata_q <= WORD_ZERO;
      endcase
    end else begin
      reg_rdata_q <= WORD_ZERO;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (start) state_q <= paint ? ST_READ : ST_STEP;
        ST_READ: if (mem_req_q && mem_ack) state_q <= ST_WRITE;
        ST_WRITE: if (mem_req_q && mem_ack) state_q <= ST_STEP;
        ST_STEP: begin
          if (at_end) begin
            state_q <= ST_DONE;
          end else if (onoff_pattern_q[pat_idx_d] || bg_sel) begin
            state_q <= ST_READ;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      x_acc_q <= ACC_ZERO;
      y_acc_q <= ACC_ZERO;
      word_addr_q <= WORD_ZERO;
      bitpos_q <= '0;
      pat_idx_q <= PAT_IDX_FIRST;
      x_moves_q <= '0;
    end else if (start) begin
      x_acc_q <= x_accum_init_q;
      y_acc_q <= y_accum_init_q;
      word_addr_q <= dest_start_addr_q;
      bitpos_q <= dest_first_q;
      pat_idx_q <= PAT_IDX_FIRST;
      x_moves_q <= '0;
    end else if (state_q == ST_STEP && !at_end) begin
      x_acc_q <= x_sum[ACC_W-1:0];
      y_acc_q <= y_sum[ACC_W-1:0];
      word_addr_q <= word_addr_d;
      bitpos_q <= bitpos_d;
      pat_idx_q <= pat_idx_d;
      x_moves_q <= x_moves_q + {12'h000, x_sum[ACC_W]};
    end
  end

  // Memory master: request held until acknowledged.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= WORD_ZERO;
      mem_wdata_q <= WORD_ZERO;
      old_word_q <= WORD_ZERO;
    end else if (mem_req_q) begin
      if (mem_ack) begin
        mem_req_q <= 1'b0;
        if (!mem_we_q) begin
          old_word_q <= mem_rdata;
        end
      end
    end else if (state_q == ST_READ) begin
      mem_req_q <= 1'b1;
      mem_we_q <= 1'b0;
      mem_addr_q <= word_addr_q;
    end else if (state_q == ST_WRITE) begin
      mem_req_q <= 1'b1;
      mem_we_q <= 1'b1;
      mem_wdata_q <= merged_word;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done_irq_q <= 1'b0;
    end else begin
      done_irq_q <= finish && engine_control_q[CTL_IRQEN];
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign done_irq = done_irq_q;
endmodule
`default_nettype wire

// file: test/lde_engine_chk.sv
// Port checker for the line-draw engine.
`timescale 1ns/100ps
`default_nettype none
module lde_engine_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [lde_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lde_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [lde_pkg::DATA_W-1:0] reg_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [lde_pkg::MEM_AW-1:0] mem_addr,
  input wire logic [lde_pkg::DATA_W-1:0] mem_wdata,
  input wire logic [lde_pkg::DATA_W-1:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic done_irq
);
  import lde_pkg::*;
  logic irqen_q;
  logic first_q;
  logic pat0_q;
  logic [MEM_AW-1:0] start_q;
  logic [MEM_AW-1:0] rdaddr_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Shadows of what software programmed and of the last address read, so the checker needs no view inside the engine.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irqen_q <= 1'b0;
      first_q <= 1'b0;
      pat0_q <= 1'b0;
      start_q <= 32'h0000_0000;
      rdaddr_q <= 32'h0000_0000;
    end else begin
      if (reg_write && reg_addr == OFF_CONTROL) begin
        irqen_q <= reg_wdata[CTL_IRQEN];
      end
      if (reg_write && reg_addr == OFF_DEST_START) begin
        start_q <= reg_wdata;
      end
      if (reg_write && reg_addr == OFF_PATTERN) begin
        pat0_q <= reg_wdata[0];
      end
      // The first access belongs to the start word only if the first pixel is painted.
      if (reg_write && reg_addr == OFF_CONTROL) begin
        first_q <= reg_wdata[CTL_ENABLE] && reg_wdata[CTL_LINE] && (pat0_q || reg_wdata[CTL_BGSEL]);
      end else if (mem_req) begin
        first_q <= 1'b0;
      end
      if (mem_req && mem_ack && !mem_we) begin
        rdaddr_q <= mem_addr;
      end
    end
  end
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before acknowledge");
  req_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request not dropped after acknowledge");
  rmw_pair_a: assert property (mem_req && mem_ack && !mem_we |=> ##[1:4] (mem_req && mem_we))
    else $error("read of a word not followed by its write");
  wr_addr_a: assert property (mem_req && mem_we |-> mem_addr == rdaddr_q)
    else $error("write address differs from the word just read");
  first_addr_a: assert property (mem_req && first_q |-> mem_addr == start_q && !mem_we)
    else $error("first access is not a read of the start word");
  irq_gate_a: assert property (done_irq |-> irqen_q ##1 !done_irq)
    else $error("completion interrupt wrong");
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  unmapped_a: assert property (reg_read && reg_addr > OFF_STATUS |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind lde_engine lde_engine_chk chk (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack), .done_irq(done_irq));
`default_nettype wire

// file: test/lde_mem_model.sv
// Behavioural frame-buffer memory with a programmable acknowledge delay.
`timescale 1ns/100ps
`default_nettype none
module lde_mem_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] ack_dly,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [lde_pkg::MEM_AW-1:0] mem_addr,
  input wire logic [lde_pkg::DATA_W-1:0] mem_wdata,
  output logic [lde_pkg::DATA_W-1:0] mem_rdata,
  output logic mem_ack
);
  import lde_pkg::*;
  logic [DATA_W-1:0] words [64];
  logic [3:0] wait_q;
  initial begin
    for (int i = 0; i < 64; i++) begin
      words[i] = {16'hc3a5, i[15:0]};
    end
  end
  assign mem_ack = mem_req && wait_q == ack_dly;
  // Outside an acknowledged read the bus shows inverted data, so a stale sample never passes.
  assign mem_rdata = (mem_ack && !mem_we) ? words[mem_addr[5:0]] : ~words[mem_addr[5:0]];
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 4'h0;
    end else begin
      wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
  always @(posedge core_clk) begin
    if (mem_ack && mem_we) begin
      words[mem_addr[5:0]] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// file: test/tb_lde_engine.sv
// Self-checking bench for the line-draw engine.
`timescale 1ns/100ps
`default_nettype none
module tb_lde_engine;
  import lde_pkg::*;
  localparam logic [31:0] FG = 32'h1234_5678;
  localparam logic [31:0] BG = 32'h9abc_def0;
  logic core_clk, reset, reg_write, reg_read, mem_req, mem_we, mem_ack, done_irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic [31:0] exp_mem [64];
  logic [3:0] ack_dly;
  int error_cnt, checks_done, irq_cnt;
  logic [71:0] rows [13] = '{72'h04_ffffffff_000fffff, 72'h08_ffffffff_0fff0fff, 72'h0c_ffffffff_0fff0fff,
    72'h10_000000a0_000000a0, 72'h14_ffffffff_00001f1f, 72'h18_ffffffff_00001f1f, 72'h20_ffffffff_00000fff,
    72'h24_ffffffff_00000fff, 72'h28_12345678_12345678, 72'h2c_9abcdef0_9abcdef0, 72'h00_fffffffe_000001fe,
    72'h30_ffffffff_00000000, 72'h40_ffffffff_00000000};
  lde_engine uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .done_irq(done_irq));
  lde_mem_model mem (.core_clk(core_clk), .reset(reset), .ack_dly(ack_dly), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (done_irq === 1'b1) irq_cnt++;
  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic draw(input logic [2:0] dep, input int fb, input logic [11:0] xi, input logic [11:0] yi,
      input int w, input logic xd, input logic yd, input logic bgs, input logic ie, input logic [15:0] pat,
      input logic [3:0] last, input logic [3:0] dly);
    int pb, bp, word, mv, idx, n;
    logic [12:0] xa, ya;
    logic [31:0] ctl;
    pb = dep == DEPTH_4 ? 4 : dep == DEPTH_8 ? 8 : dep == DEPTH_32 ? 32 : 16;
    ctl = {23'h0, ie, dep, bgs, yd, xd, 2'b10};
    n = irq_cnt;
    ack_dly <= dly;
    wr(OFF_LINE_INIT, 32'h0800_0800);
    wr(OFF_PATTERN, {12'h000, last, pat});
    wr(OFF_STRIDE, 32'h0000_0004);
    wr(OFF_DEST_PIX, fb);
    wr(OFF_DEST_START, 32'h0000_0028);
    wr(OFF_BACKGROUND, BG);
    wr(OFF_FOREGROUND, FG);
    wr(OFF_LINE_INC, {4'h0, yi, 4'h0, xi});
    wr(OFF_WIDTH, w);
    wr(OFF_HEIGHT, 32'h0000_0000);
    wr(OFF_CONTROL, 32'h0000_0000);
    wr(OFF_CONTROL, ctl);
    wr(OFF_CONTROL, ctl | 32'h0000_0001);
    xa = 13'h0800;
    ya = 13'h0800;
    word = 40;
    bp = fb;
    mv = 0;
    idx = 0;
    forever begin
      if (pat[idx] || bgs) begin
        for (int b = 0; b < pb; b++) exp_mem[word][bp+b] = pat[idx] ? FG[b] : BG[b];
      end
      if (mv == w + 1) break;
      xa = xa[11:0] + xi;
      ya = ya[11:0] + yi;
      if (xa[12]) begin
        mv++;
        bp += xd ? pb : -pb;
        if (bp > 31) begin
          word++;
          bp -= 32;
        end
        if (bp < 0) begin
          word--;
          bp += 32;
        end
      end
      if (ya[12]) word += yd ? 4 : -4;
      idx = idx == last ? 0 : idx + 1;
    end
    for (int i = 0; i < 300; i++) begin
      rdr(OFF_CONTROL);
      if (rd[CTL_ENABLE] === 1'b0) break;
    end
    chk("control after draw", ctl, rd);
    repeat (3) @(posedge core_clk);
    chk("interrupt count", n + ie, irq_cnt);
    for (int i = 0; i < 64; i++) chk("frame word", exp_mem[i], mem.words[i]);
  endtask
  initial begin
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    ack_dly = 4'h0;
    for (int i = 0; i < 64; i++) exp_mem[i] = {16'hc3a5, i[15:0]};
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][71:64], rows[i][63:32]);
      rdr(rows[i][71:64]);
      chk("register", rows[i][31:0], rd);
    end
    draw(DEPTH_8, 16, 12'hfff, 12'h800, 5, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0005, 4'h2, 4'h0);
    draw(DEPTH_16, 16, 12'h49c, 12'hfff, 1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h00f5, 4'hf, 4'h3);
    draw(DEPTH_4, 28, 12'hfff, 12'h000, 2, 1'b1, 1'b0, 1'b0, 1'b1, 16'hffff, 4'hf, 4'h1);
    draw(DEPTH_32, 0, 12'hfff, 12'hfff, 0, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0008, 4'h0, 4'h2);
    wr(OFF_CONTROL, 32'h0000_0001);
    rdr(OFF_CONTROL);
    chk("enable without line mode", 32'h0000_0000, rd);
    // Leave non-zero values behind so that the reset checks below can fail.
    wr(OFF_PATTERN, 32'h0003_00a5);
    wr(OFF_CONTROL, 32'h0000_01fe);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rdr(OFF_CONTROL);
    chk("control after reset", 32'h0000_0000, rd);
    rdr(OFF_PATTERN);
    chk("pattern after reset", 32'h0000_0000, rd);
    print_verdict;
  end
  // The whole sequence needs well under 10000 cycles; three times that means a hang.
  initial begin
    #300000;
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
